// File: design/clm_cfg.svh
// register offsets, field positions, reset values for the channel limit monitor
`ifndef CLM_CFG_SVH
`define CLM_CFG_SVH

// -----------------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------------
`define CLM_OFS_CH6_HIGH_LSB_HYST  8'h38
`define CLM_OFS_CH6_HIGH_UPPER     8'h39
`define CLM_OFS_CH6_LOW_LSB_DEB    8'h3a
`define CLM_OFS_CH6_LOW_UPPER      8'h3b
`define CLM_OFS_CH7_HIGH_LSB_HYST  8'h3c
`define CLM_OFS_CH7_HIGH_UPPER     8'h3d
`define CLM_OFS_CH7_LOW_LSB_DEB    8'h3e
`define CLM_OFS_CH7_LOW_UPPER      8'h3f
`define CLM_OFS_CH0_PEAK_LOW       8'h60
`define CLM_OFS_CH0_PEAK_HIGH      8'h61

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define CLM_NIB_HI       7
`define CLM_NIB_LO       4
`define CLM_CNT_HI       3
`define CLM_CNT_LO       0
`define CLM_HYST_SHIFT   3

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define CLM_RST_HIGH_LSB_HYST  8'hf0
`define CLM_RST_HIGH_UPPER     8'hff
`define CLM_RST_LOW_LSB_DEB    8'h00
`define CLM_RST_LOW_UPPER      8'h00
`define CLM_RST_PEAK           12'h000

`endif

// File: design/clm_pkg.sv
// types shared by the channel limit monitor files
package clm_pkg;

	// per-channel event flag state
	typedef enum logic [0:0] {
		CLM_IDLE  = 1'b0,
		CLM_EVENT = 1'b1
	} clm_state_t;

	typedef logic [11:0] clm_code_t;

endpackage : clm_pkg

// File: design/clm_chan.sv
// one channel's window comparator with debounce counter and hysteresis
`timescale 1ns/1ps
`include "clm_cfg.svh"

module clm_chan
	import clm_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// sample stream
	input  wire logic       sampleValid,
	input  wire clm_code_t  sampleCode,
	// limits
	input  wire logic [7:0] highByte,
	input  wire logic [3:0] highNibble,
	input  wire logic [7:0] lowByte,
	input  wire logic [3:0] lowNibble,
	input  wire logic [3:0] hystField,
	input  wire logic [3:0] debounceCount,
	// result
	output logic            eventFlag
);

	clm_state_t state_r, state_nxt;
	logic [3:0] run_r, run_nxt;
	logic [12:0] highLim, lowLim, hyst, code13;
	logic       above, below, beyond;

	// -------------------------------------------------------------------------
	// limit assembly
	// -------------------------------------------------------------------------
	always_comb begin
		highLim = {1'b0, highByte, highNibble};
		lowLim  = {1'b0, lowByte, lowNibble};
		hyst    = 13'(hystField) << `CLM_HYST_SHIFT;
		code13  = {1'b0, sampleCode};
		above   = code13 > highLim;
		below   = code13 < lowLim;
		beyond  = above | below;
	end

	// -------------------------------------------------------------------------
	// debounce and flag release
	// -------------------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		run_nxt   = run_r;
		if (sampleValid) begin
			case (state_r)
				CLM_IDLE: begin
					if (!beyond) begin
						run_nxt = 4'h0;
					end else if (run_r == debounceCount) begin
						state_nxt = CLM_EVENT;  // n+1 samples in a row
						run_nxt   = 4'h0;
					end else begin
						run_nxt = run_r + 4'h1;
					end
				end
				CLM_EVENT: begin
					// release only once inside the narrowed window
					if ((code13 + hyst <= highLim) && (code13 >= lowLim + hyst)) begin
						state_nxt = CLM_IDLE;
					end
				end
				default: state_nxt = CLM_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= CLM_IDLE;
			run_r   <= 4'h0;
		end else begin
			state_r <= state_nxt;
			run_r   <= run_nxt;
		end
	end

	assign eventFlag = (state_r == CLM_EVENT);

endmodule : clm_chan

// File: design/clm_top.sv
// channel limit monitor: register file, two comparator channels, peak capture
// Notes on behaviour
// - high nibble compared with result bits 3:0
// - low nibble compared with result bits 3:0
// - limit bytes compared with top eight bits
// - count n needs n+1 consecutive samples
// - hysteresis nibble shifted left three, both limits
// - high limit resets to full scale
// - low limit and count reset zero
// - peak holds largest code since read
// - peak read returns value then clears
`timescale 1ns/1ps
`include "clm_cfg.svh"

module clm_top
	import clm_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// conversion stream, same clock domain
	input  wire logic       sampleValid,
	input  wire logic [2:0] sampleChan,
	input  wire clm_code_t  sampleCode,
	// register port from the serial-bus engine
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrite,
	input  wire logic [7:0] regWdata,
	input  wire logic       regRead,
	output logic [7:0]      regRdata,
	output logic            regRvalid,
	// event flags for channels 6 and 7
	output logic [1:0]      eventFlags
);

	// limitations: only channels 6 and 7 carry a comparator and only channel 0
	// a peak register; a read and a write strobe in the same cycle are not
	// expected, the write lands and the read returns the value from before it;
	// the register port has no error answer, unmapped reads simply give zero

	// -------------------------------------------------------------------------
	// configuration registers, index 0 is channel 6
	// -------------------------------------------------------------------------
	// each monitored channel owns four bytes from its base (0x38, 0x3c):
	//   base+0  high limit nibble in [7:4], hysteresis field in [3:0]
	//   base+1  high limit byte
	//   base+2  low limit nibble in [7:4], debounce count in [3:0]
	//   base+3  low limit byte
	// the limits are twelve bits, byte above nibble, as the conversion code is;
	// channel 0 peak: 0x60 low byte, 0x61 upper four bits, both read-only
	logic [7:0] hiLsb_r [2];
	logic [7:0] hiUp_r  [2];
	logic [7:0] loLsb_r [2];
	logic [7:0] loUp_r  [2];
	logic [7:0] hiLsb_nxt [2];
	logic [7:0] hiUp_nxt  [2];
	logic [7:0] loLsb_nxt [2];
	logic [7:0] loUp_nxt  [2];
	clm_code_t  peak_r, peak_nxt;
	logic       peakHit;
	logic       peakClear;
	logic [7:0] regRdata_nxt;
	logic       regRvalid_nxt;
	logic [1:0] chanHit;
	logic [1:0] flagRaw;
	logic [1:0] eventFlags_r;

	// register writes
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			hiLsb_nxt[c] = hiLsb_r[c];
			hiUp_nxt[c]  = hiUp_r[c];
			loLsb_nxt[c] = loLsb_r[c];
			loUp_nxt[c]  = loUp_r[c];
		end
		if (regWrite) begin
			case (regAddr)
				`CLM_OFS_CH6_HIGH_LSB_HYST: hiLsb_nxt[0] = regWdata;
				`CLM_OFS_CH6_HIGH_UPPER:    hiUp_nxt[0]  = regWdata;
				`CLM_OFS_CH6_LOW_LSB_DEB:   loLsb_nxt[0] = regWdata;
				`CLM_OFS_CH6_LOW_UPPER:     loUp_nxt[0]  = regWdata;
				`CLM_OFS_CH7_HIGH_LSB_HYST: hiLsb_nxt[1] = regWdata;
				`CLM_OFS_CH7_HIGH_UPPER:    hiUp_nxt[1]  = regWdata;
				`CLM_OFS_CH7_LOW_LSB_DEB:   loLsb_nxt[1] = regWdata;
				`CLM_OFS_CH7_LOW_UPPER:     loUp_nxt[1]  = regWdata;
				default: ;  // unmapped or read-only: write ignored
			endcase
		end
	end

	// configuration registers; reset leaves the window fully open (high at full
	// scale, low at zero), so no sample can count as beyond it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int c = 0; c < 2; c++) begin
				hiLsb_r[c] <= `CLM_RST_HIGH_LSB_HYST;
				hiUp_r[c]  <= `CLM_RST_HIGH_UPPER;
				loLsb_r[c] <= `CLM_RST_LOW_LSB_DEB;
				loUp_r[c]  <= `CLM_RST_LOW_UPPER;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				hiLsb_r[c] <= hiLsb_nxt[c];
				hiUp_r[c]  <= hiUp_nxt[c];
				loLsb_r[c] <= loLsb_nxt[c];
				loUp_r[c]  <= loUp_nxt[c];
			end
		end
	end

	// -------------------------------------------------------------------------
	// comparator channels
	// -------------------------------------------------------------------------
	// entry 0 serves converter channel 6 and entry 1 channel 7; samples of any
	// other channel leave a run counter alone, so channels that are converted
	// in turn still count as consecutive samples on each of them
	assign chanHit = {sampleValid && (sampleChan == 3'h7),
	                  sampleValid && (sampleChan == 3'h6)};

	generate
		for (genvar g = 0; g < 2; g++) begin : gChan
			clm_chan uChan (
				.ref_clk       (ref_clk),
				.rst_n         (rst_n),
				.sampleValid   (chanHit[g]),
				.sampleCode    (sampleCode),
				.highByte      (hiUp_r[g]),
				.highNibble    (hiLsb_r[g][`CLM_NIB_HI:`CLM_NIB_LO]),
				.lowByte       (loUp_r[g]),
				.lowNibble     (loLsb_r[g][`CLM_NIB_HI:`CLM_NIB_LO]),
				.hystField     (hiLsb_r[g][`CLM_CNT_HI:`CLM_CNT_LO]),
				.debounceCount (loLsb_r[g][`CLM_CNT_HI:`CLM_CNT_LO]),
				.eventFlag     (flagRaw[g])
			);
		end
	endgenerate

	// -------------------------------------------------------------------------
	// read path: register decode and registered answer
	// -------------------------------------------------------------------------
	// the answer comes from flops, so the host sees it exactly one cycle after
	// its strobe, and regRdata falls back to zero between reads
	always_comb begin
		regRdata_nxt  = 8'h00;
		regRvalid_nxt = regRead;
		peakClear     = 1'b0;
		if (regRead) begin
			case (regAddr)
				`CLM_OFS_CH6_HIGH_LSB_HYST: regRdata_nxt = hiLsb_r[0];
				`CLM_OFS_CH6_HIGH_UPPER:    regRdata_nxt = hiUp_r[0];
				`CLM_OFS_CH6_LOW_LSB_DEB:   regRdata_nxt = loLsb_r[0];
				`CLM_OFS_CH6_LOW_UPPER:     regRdata_nxt = loUp_r[0];
				`CLM_OFS_CH7_HIGH_LSB_HYST: regRdata_nxt = hiLsb_r[1];
				`CLM_OFS_CH7_HIGH_UPPER:    regRdata_nxt = hiUp_r[1];
				`CLM_OFS_CH7_LOW_LSB_DEB:   regRdata_nxt = loLsb_r[1];
				`CLM_OFS_CH7_LOW_UPPER:     regRdata_nxt = loUp_r[1];
				`CLM_OFS_CH0_PEAK_LOW: begin
					regRdata_nxt = peak_r[7:0];
					peakClear    = 1'b1;
				end
				`CLM_OFS_CH0_PEAK_HIGH: begin
					regRdata_nxt = {4'h0, peak_r[11:8]};
					peakClear    = 1'b1;
				end
				default: regRdata_nxt = 8'h00;  // unmapped reads as zero
			endcase
		end
	end

	// answer registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata  <= 8'h00;
			regRvalid <= 1'b0;
		end else begin
			regRdata  <= regRdata_nxt;
			regRvalid <= regRvalid_nxt;
		end
	end

	// -------------------------------------------------------------------------
	// peak capture for channel 0
	// -------------------------------------------------------------------------
	// either half clears the whole code: a host after both halves of one peak
	// must accept that its second read only shows what came after the first
	assign peakHit = sampleValid && (sampleChan == 3'h0);

	// a sample that lands in the clearing cycle still counts: set wins over clear
	always_comb begin
		peak_nxt = peak_r;
		if (peakClear) begin
			peak_nxt = `CLM_RST_PEAK;
		end
		if (peakHit && (sampleCode > peak_nxt)) begin
			peak_nxt = sampleCode;
		end
	end

	// peak register, read-only to the host
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			peak_r <= `CLM_RST_PEAK;
		end else begin
			peak_r <= peak_nxt;
		end
	end

	// -------------------------------------------------------------------------
	// event flag outputs
	// -------------------------------------------------------------------------
	// one more stage keeps the outputs straight from flops; the cost is that a
	// flag follows its deciding sample by two clock edges instead of one
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			eventFlags_r <= 2'b00;
		end else begin
			eventFlags_r <= flagRaw;
		end
	end

	assign eventFlags = eventFlags_r;

endmodule : clm_top

// File: bench/clm_top_props.sv
// port assertions for the channel limit monitor
`timescale 1ns/1ps
module clm_top_chk (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// stream and register port
	input wire logic       sampleValid,
	input wire logic [2:0] sampleChan,
	input wire logic [7:0] regAddr,
	input wire logic       regWrite,
	input wire logic [7:0] regWdata,
	input wire logic       regRead,
	input wire logic [7:0] regRdata,
	input wire logic       regRvalid,
	input wire logic [1:0] eventFlags
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// read answer comes exactly one cycle after the strobe
	property p_ans; regRead |=> regRvalid; endproperty
	a_ans: assert property (p_ans) else $error("read not answered");
	property p_noans; !regRead |=> !regRvalid && regRdata == 8'h00; endproperty
	a_noans: assert property (p_noans) else $error("answer without read");
	property p_unmap; regRead && regAddr == 8'h00 |=> regRdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_wrrd;
		regWrite && regAddr == 8'h3c ##2 regRead && regAddr == 8'h3c
		|=> regRdata == $past(regWdata, 3);
	endproperty
	a_wrrd: assert property (p_wrrd) else $error("readback differs");
	// a peak read with no sample near it leaves zero for the next one
	property p_clr;
		regRead && regAddr[7:1] == 7'h30 && !sampleValid ##1 !sampleValid
		##1 regRead && regAddr[7:1] == 7'h30 |=> regRdata == 8'h00;
	endproperty
	a_clr: assert property (p_clr) else $error("peak not cleared");
	property p_f0; $changed(eventFlags[0]) |-> $past(sampleValid, 2) && $past(sampleChan, 2) == 3'h6;
	endproperty
	a_f0: assert property (p_f0) else $error("ch6 flag moved alone");
	property p_f1; $changed(eventFlags[1]) |-> $past(sampleValid, 2) && $past(sampleChan, 2) == 3'h7;
	endproperty
	a_f1: assert property (p_f1) else $error("ch7 flag moved alone");
	property p_one; regRvalid |=> !regRvalid || $past(regRead); endproperty
	a_one: assert property (p_one) else $error("answer held"); // no read, no second pulse
	c_rd: cover property (regRead ##1 regRvalid);
	c_ev: cover property ($rose(eventFlags[1]));
	c_ev6: cover property ($fell(eventFlags[0]));
endmodule : clm_top_chk
bind clm_top clm_top_chk u_clm_top_chk (.ref_clk, .rst_n, .sampleValid, .sampleChan, .regAddr,
	.regWrite, .regWdata, .regRead, .regRdata, .regRvalid, .eventFlags);

// File: bench/clm_src.sv
// conversion result source facing the monitor
`timescale 1ns/1ps
module clm_src (
	// clock
	input  wire logic  ref_clk,
	// result stream
	output logic        sampleValid,
	output logic [2:0]  sampleChan,
	output logic [11:0] sampleCode
);
	initial begin
		sampleValid = 1'b0;
		sampleChan = 3'h0;
		sampleCode = 12'h000;
	end
	// one-cycle result; code then inverts so a stale value cannot pass
	task send(input logic [2:0] c, input logic [11:0] d);
		@(negedge ref_clk);
		sampleValid = 1'b1;
		sampleChan = c;
		sampleCode = d;
		@(negedge ref_clk);
		sampleValid = 1'b0;
		sampleCode = ~d;
	endtask : send
endmodule : clm_src

// File: bench/test_channel_limit_monitor.sv
// self-checking bench for the channel limit monitor
`timescale 1ns/1ps
module test_channel_limit_monitor;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sampleValid;
	logic [2:0]  sampleChan;
	logic [11:0] sampleCode;
	logic [7:0]  regAddr = 8'h00;
	logic        regWrite = 1'b0;
	logic [7:0]  regWdata = 8'h00;
	logic        regRead = 1'b0;
	logic [7:0]  regRdata;
	logic        regRvalid;
	logic [1:0]  eventFlags;
	int          fail_count = 0;
	int          checks = 0;
	logic [7:0]  rstVal [8] = '{8'hf0, 8'hff, 8'h00, 8'h00, 8'hf0, 8'hff, 8'h00, 8'h00};
	always #2 ref_clk = ~ref_clk;
	clm_top u_clm_top (.ref_clk(ref_clk), .rst_n(rst_n), .sampleValid(sampleValid),
		.sampleChan(sampleChan), .sampleCode(sampleCode), .regAddr(regAddr),
		.regWrite(regWrite), .regWdata(regWdata), .regRead(regRead),
		.regRdata(regRdata), .regRvalid(regRvalid), .eventFlags(eventFlags));
	clm_src u_clm_src (.ref_clk(ref_clk), .sampleValid(sampleValid),
		.sampleChan(sampleChan), .sampleCode(sampleCode));
	task chk(input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge ref_clk);
		regWrite = 1'b0;
	endtask : wr
	// strobe one cycle, answer is looked at in the cycle it stands
	task rd(input logic [7:0] a, input logic [11:0] e);
		@(negedge ref_clk);
		regRead = 1'b1;
		regAddr = a;
		@(negedge ref_clk);
		chk({11'h000, regRvalid}, 12'h001);
		chk({4'h0, regRdata}, e);
		regRead = 1'b0;
	endtask : rd
	// flag lands two edges after the sample
	task flag(input int i, input logic e);
		repeat (2) @(negedge ref_clk);
		chk({11'h000, eventFlags[i]}, {11'h000, e});
	endtask : flag
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	initial begin
		#20000;
		fail_count++;
		report_and_stop;
	end
	initial begin
		repeat (4) @(negedge ref_clk);
		rst_n = 1'b1;
		for (int k = 0; k < 8; k++)
			rd(8'h38 + k[7:0], {4'h0, rstVal[k]});
		rd(8'h00, 12'h000);
		$display("test reset done");
		u_clm_src.send(3'h0, 12'h123);
		u_clm_src.send(3'h0, 12'habc);
		u_clm_src.send(3'h0, 12'h456);
		rd(8'h60, 12'h0bc);
		rd(8'h61, 12'h000);
		u_clm_src.send(3'h0, 12'h7ff);
		wr(8'h60, 8'hff);
		rd(8'h61, 12'h007);
		rd(8'h60, 12'h000);
		$display("test peak done");
		wr(8'h3d, 8'h80);
		wr(8'h3c, 8'h51);
		rd(8'h3c, 12'h051);
		wr(8'h3e, 8'h02);
		u_clm_src.send(3'h7, 12'h806);
		u_clm_src.send(3'h7, 12'h806);
		u_clm_src.send(3'h7, 12'h805);
		u_clm_src.send(3'h7, 12'h806);
		u_clm_src.send(3'h7, 12'h806);
		flag(1, 1'b0);
		u_clm_src.send(3'h7, 12'h806);
		flag(1, 1'b1);
		u_clm_src.send(3'h7, 12'h7fe);
		flag(1, 1'b1);
		u_clm_src.send(3'h7, 12'h7fd);
		flag(1, 1'b0);
		$display("test ch7 done");
		wr(8'h3b, 8'h10);
		wr(8'h3a, 8'h40);
		u_clm_src.send(3'h6, 12'h104);
		flag(0, 1'b0);
		u_clm_src.send(3'h6, 12'h103);
		flag(0, 1'b1);
		u_clm_src.send(3'h6, 12'h104);
		flag(0, 1'b0);
		$display("test ch6 done");
		report_and_stop;
	end
endmodule : test_channel_limit_monitor
